// [iec_map.svh]
`ifndef IEC_MAP_SVH
`define IEC_MAP_SVH
// register indices as printed; byte address is four times the index
`define IEC_IDX_PRIMARY   8'hA8
`define IEC_IDX_SECONDARY 8'hA9
`define IEC_IDX_CHANNEL   8'hBA
`define IEC_IDX_MONITOR   8'hBB
`define IEC_IDX_PRIORITY  8'hBC
`define IEC_IDX_STATUS    8'hBD
`define IEC_IDX_STATCLR   8'hBE
`define IEC_IDX_STATEN    8'hBF
// implemented-bit masks, reset values
`define IEC_MASK_PRIMARY   8'hF2
`define IEC_MASK_SECONDARY 8'hFE
`define IEC_MASK_CHANNEL   8'h0F
`define IEC_MASK_MONITOR   8'h03
`define IEC_MASK_STATUS    8'h03
`define IEC_RESET_BYTE     8'h00
`define IEC_RESET_PRIO     24'h000000
// primary register fields
`define IEC_P_GLOBAL    7
`define IEC_P_CONVERTER 6
`define IEC_P_TIMER2    5
`define IEC_P_SERIAL    4
`define IEC_P_TIMER5    1
// secondary register fields
`define IEC_S_MONDET    7
`define IEC_S_TIMER4    6
`define IEC_S_PWM       5
`define IEC_S_TIMER3    4
`define IEC_S_EXT4      3
`define IEC_S_EXT3      2
`define IEC_S_EXT2      1
// monitor register fields
`define IEC_M_CLOCKMON  1
`define IEC_M_LOWVOLT   0
// status bit positions
`define IEC_ST_ENABLE_CHANGE 0
`define IEC_ST_RESERVED_WRITE 1
// bus encodings
`define IEC_HTRANS_NONSEQ 2'h2
`define IEC_HSIZE_WORD    3'h2
`endif

// [iec_pkg.sv]
package iec_pkg;
  // one bit per request line toward the core
  typedef struct packed {
    logic       lowVolt;
    logic       clockMon;
    logic       pwm;
    logic       converter;
    logic       serial;
    logic       timer5;
    logic       timer4;
    logic       timer3;
    logic       timer2;
    logic       ext4;
    logic       ext3;
    logic       ext2;
  } iec_src_t;
  // raw flags from the peripherals
  typedef struct packed {
    iec_src_t   flag;
    logic [3:0] ext4Chan;
    logic       pwmLocal;
  } iec_flags_t;
  typedef enum logic [2:0] {
    IEC_IDLE  = 3'b001,
    IEC_WRITE = 3'b010,
    IEC_READ  = 3'b100
  } iec_state_t;
endpackage

// [iec_gate.sv]
`include "iec_map.svh"
module iec_gate
  import iec_pkg::*;
(
  input  wire iec_flags_t  flags,
  input  wire logic [7:0]  primaryEn,
  input  wire logic [7:0]  secondaryEn,
  input  wire logic [7:0]  channelEn,
  input  wire logic [7:0]  monitorEn,
  output iec_src_t         req
);
  // per-source gating; the global gate is applied last
  wire       globalOn = primaryEn[`IEC_P_GLOBAL];
  wire       ext4Any  = |(flags.ext4Chan & channelEn[3:0]);
  iec_src_t  raw;
  assign raw.ext2      = flags.flag.ext2 & secondaryEn[`IEC_S_EXT2];
  assign raw.ext3      = flags.flag.ext3 & secondaryEn[`IEC_S_EXT3];
  assign raw.ext4      = ext4Any & secondaryEn[`IEC_S_EXT4];
  assign raw.timer2    = flags.flag.timer2 & primaryEn[`IEC_P_TIMER2];
  assign raw.timer3    = flags.flag.timer3 & secondaryEn[`IEC_S_TIMER3];
  assign raw.timer4    = flags.flag.timer4 & secondaryEn[`IEC_S_TIMER4];
  assign raw.timer5    = flags.flag.timer5 & primaryEn[`IEC_P_TIMER5];
  assign raw.serial    = flags.flag.serial & primaryEn[`IEC_P_SERIAL];
  assign raw.converter = flags.flag.converter & primaryEn[`IEC_P_CONVERTER];
  assign raw.pwm       = flags.flag.pwm & flags.pwmLocal & secondaryEn[`IEC_S_PWM];
  assign raw.clockMon  = flags.flag.clockMon & secondaryEn[`IEC_S_MONDET]
                         & monitorEn[`IEC_M_CLOCKMON];
  assign raw.lowVolt   = flags.flag.lowVolt & secondaryEn[`IEC_S_MONDET]
                         & monitorEn[`IEC_M_LOWVOLT];
  assign req = globalOn ? raw : '0;
endmodule

// [iec_prio.sv]
`include "iec_map.svh"
module iec_prio
  import iec_pkg::*;
(
  input  wire iec_src_t     req,
  input  wire logic [23:0]  prioLevels,
  output logic [1:0]        topLevel,
  output logic              anyReq
);
  // highest level among requests; two bits per source, source 0 lowest bits
  always_comb
  begin
    topLevel = 2'h0;
    anyReq   = 1'b0;
    for (int i = 0; i < 12; i++)
    begin
      if (req[i])
      begin
        anyReq = 1'b1;
        if (prioLevels[2*i +: 2] > topLevel)
          topLevel = prioLevels[2*i +: 2];
      end
    end
  end
endmodule

// [interrupt_enable_control.sv]
// Chosen here: the AHB-Lite slave port.
`include "iec_map.svh"
// Contract
// - twelve sources; four ext4 channels share one request line
// - each source assigned one of four priority levels
// - each source has an enable bit in primary or secondary register; clock monitor and low voltage share one
// - primary bit 7 is global gate; zero blocks every source request
// - all enable bits clear to zero on reset
// - primary bit 6 enables converter interrupt
// - primary bits 5, 4, 1 enable timer2, serial, timer5
// - secondary bit 7 shared enable for clock monitor and low voltage
// - secondary bits 6, 5, 4 enable timer4, pwm, timer3
// - secondary bits 3, 2, 1 enable ext4, ext3, ext2; bit 0 absent
// - pwm request needs secondary bit and pwm local enable
// - channel register bits 3-0 enable the four ext4 channels
// - monitor register bits 1, 0 enable clock monitor, low voltage
module interrupt_enable_control
  import iec_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire iec_flags_t  flags,
  output iec_src_t         irqReq,
  output logic [1:0]       irqLevel,
  output logic             irqAny,
  output logic             irqOut
);
  // enable registers, priorities and event status
  logic [7:0]  primary_q;
  logic [7:0]  secondary_q;
  logic [7:0]  channel_q;
  logic [7:0]  monitor_q;
  logic [23:0] prio_q;
  logic [7:0]  status_q;
  logic [7:0]  statusEn_q;
  logic [7:0]  addrIdx_q;
  iec_state_t  state_q;
  iec_state_t  state_d;
  iec_src_t    reqNow;
  logic [1:0]  levelNow;
  logic        anyNow;
  logic [31:0] readData;

  function automatic logic [7:0] word_index(input logic [31:0] addr);
    word_index = addr[9:2];
  endfunction

  function automatic logic [7:0] masked(input logic [7:0] v, input logic [7:0] m);
    masked = v & m;
  endfunction

  // address phase decode; only whole-word transfers are taken
  wire takeXfer = hsel & hready & (htrans == `IEC_HTRANS_NONSEQ)
                  & (hsize == `IEC_HSIZE_WORD);
  wire wrPhase  = (state_q == IEC_WRITE);
  wire rdPhase  = (state_q == IEC_READ);
  wire wrPrim   = wrPhase & (addrIdx_q == `IEC_IDX_PRIMARY);
  wire wrSec    = wrPhase & (addrIdx_q == `IEC_IDX_SECONDARY);
  wire wrChan   = wrPhase & (addrIdx_q == `IEC_IDX_CHANNEL);
  wire wrMon    = wrPhase & (addrIdx_q == `IEC_IDX_MONITOR);
  wire wrPrio   = wrPhase & (addrIdx_q == `IEC_IDX_PRIORITY);
  wire wrClr    = wrPhase & (addrIdx_q == `IEC_IDX_STATCLR);
  wire wrStEn   = wrPhase & (addrIdx_q == `IEC_IDX_STATEN);
  wire [7:0] wbyte = hwdata[7:0];

  // events: any enable-register write, and a write of one into a must-be-zero bit of the primary register
  wire evChange = wrPrim | wrSec | wrChan | wrMon;
  wire evResv   = wrPrim & (|(wbyte & ~`IEC_MASK_PRIMARY));
  wire [7:0] evSet = {6'h00, evResv, evChange};
  wire [7:0] clrBits = wrClr ? wbyte : 8'h00;

  // state sequencing of the bus slave
  always_comb
  begin
    case (state_q)
      IEC_IDLE, IEC_WRITE, IEC_READ:
        state_d = takeXfer ? (hwrite ? IEC_WRITE : IEC_READ) : IEC_IDLE;
      default:
        state_d = IEC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q   <= IEC_IDLE;
      addrIdx_q <= `IEC_RESET_BYTE;
    end
    else
    begin
      state_q <= state_d;
      if (takeXfer)
        addrIdx_q <= word_index(haddr);
    end
  end

  // enable registers; unimplemented bits stay zero
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      primary_q   <= `IEC_RESET_BYTE;
      secondary_q <= `IEC_RESET_BYTE;
      channel_q   <= `IEC_RESET_BYTE;
      monitor_q   <= `IEC_RESET_BYTE;
      prio_q      <= `IEC_RESET_PRIO;
    end
    else
    begin
      if (wrPrim)
        primary_q <= masked(wbyte, `IEC_MASK_PRIMARY);
      if (wrSec)
        secondary_q <= masked(wbyte, `IEC_MASK_SECONDARY);
      if (wrChan)
        channel_q <= masked(wbyte, `IEC_MASK_CHANNEL);
      if (wrMon)
        monitor_q <= masked(wbyte, `IEC_MASK_MONITOR);
      if (wrPrio)
        prio_q <= hwdata[23:0];
    end
  end

  // sticky status: a set in the same cycle as its clear wins
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      status_q   <= `IEC_RESET_BYTE;
      statusEn_q <= `IEC_RESET_BYTE;
    end
    else
    begin
      status_q <= masked((status_q & ~clrBits) | evSet, `IEC_MASK_STATUS);
      if (wrStEn)
        statusEn_q <= masked(wbyte, `IEC_MASK_STATUS);
    end
  end

  // read mux on the address phase, so the registered data stands in the data phase
  always_comb
  begin
    case (word_index(haddr))
      `IEC_IDX_PRIMARY:   readData = {24'h000000, primary_q};
      `IEC_IDX_SECONDARY: readData = {24'h000000, secondary_q};
      `IEC_IDX_CHANNEL:   readData = {24'h000000, channel_q};
      `IEC_IDX_MONITOR:   readData = {24'h000000, monitor_q};
      `IEC_IDX_PRIORITY:  readData = {8'h00, prio_q};
      `IEC_IDX_STATUS:    readData = {24'h000000, status_q};
      `IEC_IDX_STATEN:    readData = {24'h000000, statusEn_q};
      default:            readData = 32'h00000000;
    endcase
  end

  // gating and priority are combinational; outputs are registered below
  iec_gate u_gate (
    .flags       (flags),
    .primaryEn   (primary_q),
    .secondaryEn (secondary_q),
    .channelEn   (channel_q),
    .monitorEn   (monitor_q),
    .req         (reqNow)
  );

  iec_prio u_prio (
    .req        (reqNow),
    .prioLevels (prio_q),
    .topLevel   (levelNow),
    .anyReq     (anyNow)
  );

  // registered outputs; one cycle of latency from flag to request
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      irqReq    <= '0;
      irqLevel  <= 2'h0;
      irqAny    <= 1'b0;
      irqOut    <= 1'b0;
    end
    else
    begin
      hrdata    <= (takeXfer & ~hwrite) ? readData : 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      irqReq    <= reqNow;
      irqLevel  <= levelNow;
      irqAny    <= anyNow;
      irqOut    <= |(status_q & statusEn_q);
    end
  end

  // zero-wait read: data must stand during the data phase itself
  chk_read_primary: assert property (@(posedge clk) disable iff (!reset_n)
    rdPhase && (addrIdx_q == `IEC_IDX_PRIMARY) && $stable(primary_q)
      |-> hrdata == {24'h000000, primary_q})
    else $error("primary enable readback wrong");

  chk_global_block: assert property (@(posedge clk) disable iff (!reset_n)
    !primary_q[`IEC_P_GLOBAL] |=> irqReq == '0)
    else $error("request passed with global gate off");
  chk_pwm_both: assert property (@(posedge clk) disable iff (!reset_n)
    (reqNow.pwm) |-> flags.pwmLocal && secondary_q[`IEC_S_PWM])
    else $error("pwm request without both enables");
  chk_ext4_channel: assert property (@(posedge clk) disable iff (!reset_n)
    reqNow.ext4 |-> |(flags.ext4Chan & channel_q[3:0]))
    else $error("ext4 request from disabled channel");
  chk_mon_shared: assert property (@(posedge clk) disable iff (!reset_n)
    (reqNow.clockMon || reqNow.lowVolt) |-> secondary_q[`IEC_S_MONDET])
    else $error("monitor request without shared enable");
  chk_mon_own: assert property (@(posedge clk) disable iff (!reset_n)
    reqNow.clockMon |-> monitor_q[`IEC_M_CLOCKMON])
    else $error("clock monitor request without own enable");
  chk_prim_write: assert property (@(posedge clk) disable iff (!reset_n)
    wrPrim |=> primary_q == $past(wbyte & `IEC_MASK_PRIMARY))
    else $error("primary enable write not stored");
  chk_reserved_zero: assert property (@(posedge clk) disable iff (!reset_n)
    primary_q[3] == 1'b0 && secondary_q[0] == 1'b0)
    else $error("unimplemented enable bit set");
  chk_timer5_flow: assert property (@(posedge clk) disable iff (!reset_n)
    flags.flag.timer5 && primary_q[`IEC_P_TIMER5] && primary_q[`IEC_P_GLOBAL]
      |=> irqReq.timer5)
    else $error("enabled timer5 request lost");
  chk_adc_flow: assert property (@(posedge clk) disable iff (!reset_n)
    reqNow.converter |-> primary_q[`IEC_P_CONVERTER])
    else $error("converter request while disabled");
  chk_sec_timers: assert property (@(posedge clk) disable iff (!reset_n)
    (reqNow.timer4 |-> secondary_q[`IEC_S_TIMER4]) and
    (reqNow.timer3 |-> secondary_q[`IEC_S_TIMER3]))
    else $error("timer request while disabled");
  chk_irq_level: assert property (@(posedge clk) disable iff (!reset_n)
    |(status_q & statusEn_q) |=> irqOut)
    else $error("interrupt output missed enabled status");
endmodule

// [iec_core_model.sv]
// stands in for the core: samples the request lines once per cycle
module iec_core_model
  import iec_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     reset_n,
  input  wire iec_src_t irqReq,
  input  wire logic     irqAny,
  output iec_src_t      pendingVec_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // the four ext4 channels reach the core as one shared line
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      pendingVec_q <= '0;
    else
      pendingVec_q <= irqAny ? irqReq : '0;
endmodule

// [tb_top.sv]
`include "iec_map.svh"
module tb_top
  import iec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [16:0] ALLFLAGS = 17'h1FFFF;
  logic        clk;
  logic        reset_n;
  logic        hsel;
  logic        hwrite;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [1:0]  htrans;
  logic [1:0]  irqLevel;
  logic [2:0]  hsize;
  logic        hreadyout;
  logic        hresp;
  logic        irqAny;
  logic        irqOut;
  iec_flags_t  flags;
  iec_src_t    irqReq;
  iec_src_t    pendingVec;
  int          fails;
  int          nTests;

  interrupt_enable_control u_dut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .flags(flags), .irqReq(irqReq),
    .irqLevel(irqLevel), .irqAny(irqAny), .irqOut(irqOut));
  iec_core_model u_core (.clk(clk), .reset_n(reset_n), .irqReq(irqReq), .irqAny(irqAny),
    .pendingVec_q(pendingVec));

  // free-running 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp)
    begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      fails++;
    end
  endtask

  // bounded wait for the slave to take the phase; a hang ends the run
  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1)
    begin
      fails++;
      stop_test();
    end
  endtask

  // one single word transfer; read data taken at the edge ending the data phase
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= `IEC_HTRANS_NONSEQ;
    haddr  <= {22'h0, idx, 2'b00};
    hwrite <= wr;
    hsize  <= `IEC_HSIZE_WORD;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? wd : 32'h0;
    wait_ready();
    rd = hrdata;
  endtask

  // apply flags, program all four enables, then compare the gated requests
  task automatic check_case(input logic [7:0] p, input logic [7:0] s, input logic [7:0] c,
                            input logic [7:0] m, input logic [16:0] fl, input logic [11:0] exp);
    flags <= fl;
    xfer(1'b1, `IEC_IDX_PRIMARY, {24'h0, p});
    xfer(1'b1, `IEC_IDX_SECONDARY, {24'h0, s});
    xfer(1'b1, `IEC_IDX_CHANNEL, {24'h0, c});
    xfer(1'b1, `IEC_IDX_MONITOR, {24'h0, m});
    repeat (4) @(posedge clk);
    cmp({20'h0, irqReq}, {20'h0, exp});
    cmp({20'h0, pendingVec}, {20'h0, exp});
    cmp({31'h0, irqAny}, {31'h0, |exp});
  endtask

  task automatic check_irq(input logic [7:0] idx, input logic [31:0] wd, input logic exp);
    xfer(1'b1, idx, wd);
    repeat (4) @(posedge clk);
    cmp({31'h0, irqOut}, {31'h0, exp});
  endtask

  // main sequence; every flag is set high at time zero to expose leaks
  initial
  begin
    fails   = 0;
    nTests  = 0;
    reset_n = 1'b0;
    hsel    = 1'b0;
    hwrite  = 1'b0;
    haddr   = 32'h0;
    hwdata  = 32'h0;
    htrans  = 2'h0;
    hsize   = `IEC_HSIZE_WORD;
    flags   = ALLFLAGS;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    xfer(1'b0, `IEC_IDX_PRIMARY, 32'h0);
    cmp(rd, 32'h0);
    repeat (2) @(posedge clk);
    cmp({20'h0, irqReq}, 32'h0);
    check_case(8'h72, 8'hFE, 8'h0F, 8'h03, ALLFLAGS, 12'h000);
    check_case(8'hF2, 8'hFE, 8'h0F, 8'h03, ALLFLAGS, 12'hFFF);
    check_case(8'h80, 8'h02, 8'h00, 8'h00, ALLFLAGS, 12'h001);
    check_case(8'h80, 8'h04, 8'h00, 8'h00, ALLFLAGS, 12'h002);
    check_case(8'h80, 8'h08, 8'h01, 8'h00, ALLFLAGS, 12'h004);
    check_case(8'hA0, 8'h00, 8'h00, 8'h00, ALLFLAGS, 12'h008);
    check_case(8'h80, 8'h10, 8'h00, 8'h00, ALLFLAGS, 12'h010);
    check_case(8'h80, 8'h40, 8'h00, 8'h00, ALLFLAGS, 12'h020);
    check_case(8'h82, 8'h00, 8'h00, 8'h00, ALLFLAGS, 12'h040);
    check_case(8'h90, 8'h00, 8'h00, 8'h00, ALLFLAGS, 12'h080);
    check_case(8'hC0, 8'h00, 8'h00, 8'h00, ALLFLAGS, 12'h100);
    check_case(8'h80, 8'h20, 8'h00, 8'h00, ALLFLAGS, 12'h200);
    check_case(8'h80, 8'h20, 8'h00, 8'h00, 17'h1FFFE, 12'h000);
    check_case(8'h80, 8'h80, 8'h00, 8'h02, ALLFLAGS, 12'h400);
    check_case(8'h80, 8'h80, 8'h00, 8'h01, ALLFLAGS, 12'h800);
    check_case(8'h80, 8'h00, 8'h00, 8'h03, ALLFLAGS, 12'h000);
    check_case(8'h80, 8'h80, 8'h00, 8'h00, ALLFLAGS, 12'h000);
    check_case(8'h80, 8'h08, 8'h04, 8'h00, 17'h1FFE9, 12'h004);
    check_case(8'h80, 8'h08, 8'h0B, 8'h00, 17'h1FFE9, 12'h000);
    // the bench clears every flag itself, as software must
    check_case(8'hF2, 8'hFE, 8'h0F, 8'h03, 17'h00000, 12'h000);
    // priority level of the winning source
    xfer(1'b1, `IEC_IDX_PRIORITY, 32'h000000C0);
    check_case(8'hA0, 8'h00, 8'h00, 8'h00, ALLFLAGS, 12'h008);
    cmp({30'h0, irqLevel}, 32'h3);
    xfer(1'b1, `IEC_IDX_PRIORITY, 32'h00000002);
    check_case(8'h80, 8'h02, 8'h00, 8'h00, ALLFLAGS, 12'h001);
    cmp({30'h0, irqLevel}, 32'h2);
    // readback, and an unmapped place that must stay inert
    xfer(1'b1, `IEC_IDX_PRIMARY, 32'h00000082);
    xfer(1'b0, `IEC_IDX_PRIMARY, 32'h0);
    cmp(rd, 32'h00000082);
    xfer(1'b1, 8'h40, 32'hFFFFFFFF);
    xfer(1'b0, 8'h40, 32'h0);
    cmp(rd, 32'h0);
    check_case(8'h00, 8'h00, 8'h00, 8'h00, ALLFLAGS, 12'h000);
    // sticky status, masking and clearing of the level interrupt
    check_irq(`IEC_IDX_STATEN, 32'h2, 1'b0);
    check_irq(`IEC_IDX_STATCLR, 32'h3, 1'b0);
    check_irq(`IEC_IDX_PRIMARY, 32'h1, 1'b1);
    check_irq(`IEC_IDX_STATCLR, 32'h2, 1'b0);
    check_irq(`IEC_IDX_PRIMARY, 32'h0, 1'b0);
    check_irq(`IEC_IDX_STATEN, 32'h3, 1'b1);
    // a second reset in mid-run must drop every enable
    check_case(8'hF2, 8'hFE, 8'h0F, 8'h03, ALLFLAGS, 12'hFFF);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    cmp({20'h0, irqReq}, 32'h0);
    cmp({31'h0, irqOut}, 32'h0);
    stop_test();
  end
endmodule
